// ### logic/nte_pkg.sv
package nte_pkg;

  // ---------------------------------------------
  // Bus and register geometry
  // ---------------------------------------------
  localparam int          ADDR_W   = 12;
  localparam int          NUM_EVT  = 15;
  localparam logic [11:0] SC_OFS   = 12'h200;
  localparam logic [11:0] IE_OFS   = 12'h300;
  localparam logic [31:0] SC_RST   = 32'h0000_0000;
  localparam logic [31:0] IE_RST   = 32'h0000_0000;
  localparam logic        EVT_RST  = 1'h0;

  // Event flag offsets, one word each, in event index order
  localparam logic [11:0] EVT_OFS [NUM_EVT] = '{
    12'h100, 12'h104, 12'h108, 12'h10c, 12'h110,
    12'h114, 12'h118, 12'h11c, 12'h128, 12'h12c,
    12'h130, 12'h138, 12'h148, 12'h14c, 12'h150};

  // Enable bit of each event inside the mask word
  localparam int EVT_IE_BIT [NUM_EVT] = '{
    0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 14, 18, 19, 20};

  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int          SC_WAKE_BIT  = 0;
  localparam int          SC_WATCH_BIT = 1;
  localparam int          SC_RXGO_BIT  = 5;
  localparam logic [31:0] SC_VALID     = 32'h0000_0023;
  localparam logic [31:0] IE_VALID     = 32'h001c_5cff;
  localparam int          EVT_FLAG_BIT = 0;

  // Event index of the events that fire shortcuts, and of the DMA-ready event
  localparam int EVT_CARRIER_SEEN = 1;
  localparam int EVT_CARRIER_GONE = 2;
  localparam int EVT_TX_LAST      = 4;
  localparam int EVT_DMA_READY    = 14;

  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } nte_bus_state_type;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] nte_lane_mask(input logic [3:0] be);
    nte_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : nte_lane_mask

endpackage : nte_pkg

// ### logic/nte_event_cell.sv
`timescale 1ns/1ns
module nte_event_cell
  import nte_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Event source
  input  wire logic event_pulse,
  // Software access
  input  wire logic wr_strobe,
  input  wire logic wr_bit,
  // Flag state
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } nte_cell_state_type;

  nte_cell_state_type state_ff;
  nte_cell_state_type nxt_state;

  // Hardware event wins over a software clear in the same cycle
  always_comb begin
    nxt_state = state_ff;
    if (wr_strobe) begin
      nxt_state.flag = wr_bit; // R2
    end
    if (event_pulse) begin
      nxt_state.flag = 1'b1; // R2
    end
  end

  // Flag register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '{flag: EVT_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flag = state_ff.flag;

endmodule : nte_event_cell

// ### logic/nte_regs.sv
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
// What this block does
// R1: Set the DMA-ready flag when the DMA engine reports ready.
// R2: Event flags read 0 until set, 1 after; software RW; reset zero.
// R3: Carrier-seen shortcut bit set fires wake task on carrier-seen event.
// R4: Carrier-gone shortcut bit set fires watch task on carrier-gone event.
// R5: Tx-done shortcut bit set fires receive-arming task on last tx symbol.
// R6: Mask bit for peripheral-ready event; 1 allows its interrupt, 0 blocks.
// R7: Separate mask bits for carrier-seen and carrier-gone events.
// R8: Carrier-gone interrupt is masked independently of carrier-seen.
// R9: Separate mask bits for tx first symbol and tx last symbol.
// R10: Tx last symbol interrupt gated by its own bit, 1 enables.
// R11: Separate mask bits for rx first symbol and rx checked events.
// R12: Rx checked interrupt gated independently of rx first symbol.
// R13: Mask bits for general error and rx frame fault, separate.
// R14: Rx frame fault interrupt gated separately from general error.
// R15: Mask bit for rx buffer full; 1 lets it raise interrupt.
// R16: Carrier-seen event raised when reader field is sensed.
// R17: Carrier-gone event raised when reader field disappears.
// R18: Tx last symbol event raised at end of frame's last symbol.
// R19: Rx buffer full event raised when the receive buffer fills.
// R20: Interrupt line high while any flag and its enable are both 1.
// R21: Shortcut task pulses in the cycle after its firing event.
module nte_regs
  import nte_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Events from the frame engine, one-cycle pulses
  input  wire logic              peripheral_ready_event,
  input  wire logic              carrier_seen_event,
  input  wire logic              carrier_gone_event,
  input  wire logic              tx_first_symbol_event,
  input  wire logic              tx_last_symbol_event,
  input  wire logic              rx_first_symbol_event,
  input  wire logic              rx_checked_event,
  input  wire logic              general_fault_event,
  input  wire logic              rx_frame_fault_event,
  input  wire logic              rx_buffer_full_event,
  input  wire logic              tx_drained_event,
  input  wire logic              anticoll_begin_event,
  input  wire logic              anticoll_clash_event,
  input  wire logic              anticoll_won_event,
  input  wire logic              dma_ready_event,
  // Task triggers, one-cycle pulses
  output logic                   wake_frontend_task,
  output logic                   carrier_watch_task,
  output logic                   arm_receive_task,
  // Interrupt request, level
  output logic                   irq
);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    nte_bus_state_type bus_st;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [31:0]       links;
    logic [31:0]       ie_mask;
    logic              wake;
    logic              watch;
    logic              rx_go;
    logic              irq;
  } nte_main_state_type;

  nte_main_state_type state_ff;
  nte_main_state_type nxt_state;

  logic [NUM_EVT-1:0] evt_in;
  logic [NUM_EVT-1:0] evt_hit;
  logic [NUM_EVT-1:0] evt_wr;
  logic [NUM_EVT-1:0] evt_flag;
  logic [NUM_EVT-1:0] evt_gate;
  logic [31:0]        lane;
  logic               sc_hit;
  logic               ie_hit;
  logic               commit_wr;
  logic [31:0]        rd_value;

  // ---------------------------------------------
  // Event inputs gathered by event index
  // ---------------------------------------------
  // Sources are on this clock already, so no synchroniser is placed
  assign evt_in[0]                = peripheral_ready_event;
  assign evt_in[EVT_CARRIER_SEEN] = carrier_seen_event; // R16
  assign evt_in[EVT_CARRIER_GONE] = carrier_gone_event; // R17
  assign evt_in[3]                = tx_first_symbol_event;
  assign evt_in[EVT_TX_LAST]      = tx_last_symbol_event; // R18
  assign evt_in[5]                = rx_first_symbol_event;
  assign evt_in[6]                = rx_checked_event;
  assign evt_in[7]                = general_fault_event;
  assign evt_in[8]                = rx_frame_fault_event;
  assign evt_in[9]                = rx_buffer_full_event; // R19
  assign evt_in[10]               = tx_drained_event;
  assign evt_in[11]               = anticoll_begin_event;
  assign evt_in[12]               = anticoll_clash_event;
  assign evt_in[13]               = anticoll_won_event;
  assign evt_in[EVT_DMA_READY]    = dma_ready_event; // R1

  // ---------------------------------------------
  // Address decode and write commit
  // ---------------------------------------------
  // Writes land at the edge where waitrequest is seen low, so address
  // and data are sampled while the master still holds them
  assign commit_wr = (state_ff.bus_st == BUS_ACK) & write;
  assign lane      = nte_lane_mask(byteenable);
  assign sc_hit    = (address == SC_OFS);
  assign ie_hit    = (address == IE_OFS);

  // ---------------------------------------------
  // Event flags, one cell per event
  // ---------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      // Flag word decode; only byte lane 0 holds the flag
      assign evt_hit[gi] = (address == EVT_OFS[gi]);
      assign evt_wr[gi]  = commit_wr & evt_hit[gi] & byteenable[0];

      nte_event_cell u_cell (
        .clock       (clock),
        .resetn      (resetn),
        .event_pulse (evt_in[gi]),
        .wr_strobe   (evt_wr[gi]),
        .wr_bit      (writedata[EVT_FLAG_BIT]),
        .flag        (evt_flag[gi])
      );

      // Each flag is gated only by its own mask bit
      assign evt_gate[gi] = evt_flag[gi] & state_ff.ie_mask[EVT_IE_BIT[gi]]; // R20
    end
  endgenerate

  // ---------------------------------------------
  // Read value
  // ---------------------------------------------
  // Unmapped words and undefined bits read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (|evt_hit) begin
      rd_value[EVT_FLAG_BIT] = |(evt_hit & evt_flag); // R2
    end
    if (sc_hit) begin
      rd_value = state_ff.links & SC_VALID;
    end
    if (ie_hit) begin
      rd_value = state_ff.ie_mask & IE_VALID;
    end
  end

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    // Bus handshake: one wait cycle per access, then one ack cycle
    unique case (state_ff.bus_st)
      BUS_IDLE: begin
        if (read | write) begin
          nxt_state.bus_st  = BUS_ACK;
          nxt_state.waitreq = 1'b0;
          nxt_state.rdata   = read ? rd_value : 32'h0000_0000;
        end
      end
      BUS_ACK: begin
        nxt_state.bus_st  = BUS_IDLE;
        nxt_state.waitreq = 1'b1;
      end
      default: begin
        nxt_state.bus_st  = BUS_IDLE;
        nxt_state.waitreq = 1'b1;
      end
    endcase

    // Shortcut register, lane-masked write of defined bits only
    if (commit_wr & sc_hit) begin
      nxt_state.links = (state_ff.links & ~(lane & SC_VALID))
                      | (writedata & lane & SC_VALID);
    end

    // Mask register; every defined bit is its own enable
    if (commit_wr & ie_hit) begin
      nxt_state.ie_mask = (state_ff.ie_mask & ~(lane & IE_VALID)) // R6 R7 R9 R11 R13 R15
                        | (writedata & lane & IE_VALID); // R8 R10 R12 R14
    end

    // Shortcuts fire the task one cycle after the event
    nxt_state.wake  = evt_in[EVT_CARRIER_SEEN]
                    & state_ff.links[SC_WAKE_BIT]; // R3 R21
    nxt_state.watch = evt_in[EVT_CARRIER_GONE]
                    & state_ff.links[SC_WATCH_BIT]; // R4 R21
    nxt_state.rx_go = evt_in[EVT_TX_LAST]
                    & state_ff.links[SC_RXGO_BIT]; // R5 R21

    // Registered so the line never glitches on decode
    nxt_state.irq = |evt_gate; // R20
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff.bus_st  <= BUS_IDLE;
      state_ff.waitreq <= 1'b1;
      state_ff.rdata   <= 32'h0000_0000;
      state_ff.links   <= SC_RST;
      state_ff.ie_mask <= IE_RST;
      state_ff.wake    <= 1'b0;
      state_ff.watch   <= 1'b0;
      state_ff.rx_go   <= 1'b0;
      state_ff.irq     <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  // Every output is a flip-flop of the state struct
  assign readdata           = state_ff.rdata;
  assign waitrequest        = state_ff.waitreq;
  assign wake_frontend_task = state_ff.wake;
  assign carrier_watch_task = state_ff.watch;
  assign arm_receive_task   = state_ff.rx_go;
  assign irq                = state_ff.irq;

endmodule : nte_regs

// ### sim/nte_regs_checker.sv
`timescale 1ns/1ns
module nte_regs_checker
  import nte_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Bus handshake
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  // Events, tasks, interrupt
  input wire logic        carrier_seen_event,
  input wire logic        carrier_gone_event,
  input wire logic        tx_last_symbol_event,
  input wire logic        wake_frontend_task,
  input wire logic        carrier_watch_task,
  input wire logic        arm_receive_task,
  input wire logic        irq
);
  // ----------
  // Checks
  // ----------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Request seen by an idle slave
  sequence s_taken;
    (read || write) && waitrequest;
  endsequence
  // Acknowledge cycle
  sequence s_ack;
    !waitrequest;
  endsequence
  bus_answer_a: assert property (s_taken |=> s_ack)
    else $error("request not answered");
  ack_single_a: assert property (s_ack |=> waitrequest)
    else $error("acknowledge too long");
  bus_quiet_a: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("acknowledge without request");
  wr_zero_a: assert property (!waitrequest && $past(write) |-> readdata == 32'h0)
    else $error("write ack data not zero");
  reset_idle_a: assert property ($rose(resetn) |-> waitrequest && !irq)
    else $error("not idle after reset");
  // A task pulse always traces back to its event one cycle earlier
  wake_cause_a: assert property (wake_frontend_task |-> $past(carrier_seen_event))
    else $error("wake task without event");
  watch_cause_a: assert property (carrier_watch_task |-> $past(carrier_gone_event))
    else $error("watch task without event");
  rx_task_cause_a: assert property (arm_receive_task |-> $past(tx_last_symbol_event))
    else $error("receive task without event");
endmodule : nte_regs_checker

bind nte_regs nte_regs_checker chk_i (
  .clock(clock), .resetn(resetn), .read(read), .write(write),
  .waitrequest(waitrequest), .readdata(readdata),
  .carrier_seen_event(carrier_seen_event), .carrier_gone_event(carrier_gone_event),
  .tx_last_symbol_event(tx_last_symbol_event), .wake_frontend_task(wake_frontend_task),
  .carrier_watch_task(carrier_watch_task), .arm_receive_task(arm_receive_task), .irq(irq));

// ### sim/nfc_tag_event_shortcut_irq_tb.sv
`timescale 1ns/1ns
module nfc_tag_event_shortcut_irq_tb import nte_pkg::*;;
  // ----------
  // Bench signals
  // ----------
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [11:0] address = 12'h000;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic [14:0] ev = 15'h0;
  logic [3:0]  be = 4'hf;
  logic [2:0]  tk;
  logic        waitrequest, irq;
  int          n_errors = 0;
  int          compares = 0;
  always #4 clock = ~clock;
  // Events indexed in port order
  nte_regs uut (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .byteenable(be), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .peripheral_ready_event(ev[0]),
    .carrier_seen_event(ev[1]), .carrier_gone_event(ev[2]),
    .tx_first_symbol_event(ev[3]), .tx_last_symbol_event(ev[4]),
    .rx_first_symbol_event(ev[5]), .rx_checked_event(ev[6]),
    .general_fault_event(ev[7]), .rx_frame_fault_event(ev[8]),
    .rx_buffer_full_event(ev[9]), .tx_drained_event(ev[10]),
    .anticoll_begin_event(ev[11]), .anticoll_clash_event(ev[12]),
    .anticoll_won_event(ev[13]), .dma_ready_event(ev[14]),
    .wake_frontend_task(tk[0]), .carrier_watch_task(tk[1]),
    .arm_receive_task(tk[2]), .irq(irq));
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Only the watchdog ends a wait that never gets an answer
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // One-cycle event pulse; returns at the edge that samples it
  task automatic pulse(input int i);
    @(posedge clock);
    ev <= 15'h1 << i;
    @(posedge clock);
    ev <= 15'h0;
  endtask : pulse
  // Reset values, writable fields, unmapped place
  task automatic t_regs();
    bus(1'b0, 12'h150, 32'h0);
    chk("ready flag", 32'h0, q);
    bus(1'b0, SC_OFS, 32'h0);
    chk("links", 32'h0, q);
    bus(1'b0, IE_OFS, 32'h0);
    chk("mask", 32'h0, q);
    bus(1'b1, SC_OFS, '1);
    bus(1'b0, SC_OFS, 32'h0);
    chk("links", 32'h0000_0023, q);
    bus(1'b1, IE_OFS, '1);
    bus(1'b0, IE_OFS, 32'h0);
    chk("mask", 32'h001c_5cff, q);
    be <= 4'h1;
    bus(1'b1, IE_OFS, 32'h0);
    be <= 4'hf;
    bus(1'b0, IE_OFS, 32'h0);
    chk("mask lane", 32'h001c_5c00, q);
    bus(1'b0, 12'h400, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask : t_regs
  // Each flag sets, is gated by its own enable bit alone, then clears
  task automatic t_irq();
    for (int i = 0; i < NUM_EVT; i++) begin
      bus(1'b1, IE_OFS, 32'h001c_5cff & ~(32'h1 << EVT_IE_BIT[i]));
      pulse(i);
      repeat (3) @(posedge clock);
      chk("irq masked", 32'h0, irq);
      bus(1'b0, EVT_OFS[i], 32'h0);
      chk("flag", 32'h1, q);
      bus(1'b1, IE_OFS, 32'h1 << EVT_IE_BIT[i]);
      repeat (2) @(posedge clock);
      chk("irq", 32'h1, irq);
      bus(1'b1, EVT_OFS[i], 32'h0);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, irq);
    end
  endtask : t_irq
  // Linked events fire a one-cycle task; unlinked ones stay quiet
  task automatic t_links();
    int e[3] = '{EVT_CARRIER_SEEN, EVT_CARRIER_GONE, EVT_TX_LAST};
    bus(1'b1, IE_OFS, 32'h0);
    for (int en = 1; en >= 0; en--) begin
      bus(1'b1, SC_OFS, en ? 32'h23 : 32'h0);
      for (int k = 0; k < 3; k++) begin
        pulse(e[k]);
        chk("task early", 32'h0, tk);
        @(posedge clock);
        chk("task", en ? 32'h1 << k : 32'h0, tk);
        @(posedge clock);
        chk("task end", 32'h0, tk);
      end
    end
  endtask : t_links
  // Verdict
  task automatic results();
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_irq();
    t_links();
    results();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule : nfc_tag_event_shortcut_irq_tb
